/* verilog/bts_unit.sv */
// Decode and execute logic for the two bit-test-and-skip instructions
`timescale 1ns/1ps
`include "bts_defs.svh"

// Overview of operation
// - Skip-if-clear skips the next instruction when the tested bit is 0
// - Skip-if-set skips the next instruction when the tested bit is 1
// - Successful skip-if-clear flushes the prefetch, runs a NOP, takes two cycles
// - Successful skip-if-set flushes the prefetch, runs a NOP, takes two cycles
// - Register operand is 7 bits (0..127), bit operand is 3 bits (0..7)
// - Skip-if-clear decodes from leading bits 01 10, then bit and address fields
// - Skip-if-set decodes from leading bits 01 11, then same fields
module bts_unit #(
	parameter int ADDR_W = 7,
	parameter int BIT_W = 3,
	parameter int DATA_W = 8
) (
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CE,
	// Instruction from fetch
	input wire logic INSTR_VALID,
	input wire logic [13:0] INSTR,
	// File register read port
	input wire logic [DATA_W-1:0] FILE_RDATA,
	output logic FILE_RD,
	output logic [ADDR_W-1:0] FILE_ADDR,
	// Write strobes toward the rest of the core
	output logic FILE_WE,
	output logic W_WE,
	output logic STATUS_WE,
	// Sequencing back to fetch
	output logic BUSY,
	output logic FLUSH,
	output logic NOP_ACTIVE,
	output logic DONE,
	output logic SKIP_TAKEN,
	output logic [1:0] EXEC_CYCLES
);

	// ************************************************************
	// Decode
	// ************************************************************
	function automatic logic pick_bit(input logic [DATA_W-1:0] data, input logic [BIT_W-1:0] sel);
		pick_bit = data[sel];
	endfunction

	function automatic logic skip_test(input bts_pkg::bts_kind_t kind, input logic bitval);
		skip_test = (kind == bts_pkg::BTS_KIND_SET) ? bitval : ~bitval;
	endfunction

	bts_pkg::bts_state_t state_q;
	bts_pkg::bts_state_t state_d;
	bts_pkg::bts_kind_t kind_q;
	logic [BIT_W-1:0] bit_q;
	logic [3:0] opc;
	logic is_clear;
	logic is_set;
	logic take;
	logic skip_now;

	assign opc = INSTR[`BTS_OPC_MSB:`BTS_OPC_LSB];
	assign is_clear = (opc == `BTS_OPC_CLEAR);
	assign is_set = (opc == `BTS_OPC_SET);
	// Only accepted while idle; fetch must hold off while BUSY is high
	assign take = INSTR_VALID && (is_clear || is_set) && (state_q == bts_pkg::BTS_IDLE);
	assign skip_now = (state_q == bts_pkg::BTS_READ)
		&& skip_test(kind_q, pick_bit(FILE_RDATA, bit_q));

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			bts_pkg::BTS_IDLE: begin
				if (take) begin
					state_d = bts_pkg::BTS_READ;
				end
			end
			bts_pkg::BTS_READ: begin
				state_d = skip_now ? bts_pkg::BTS_NOP : bts_pkg::BTS_IDLE;
			end
			bts_pkg::BTS_NOP: begin
				state_d = bts_pkg::BTS_IDLE;
			end
			default: begin
				state_d = bts_pkg::BTS_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			state_q <= bts_pkg::BTS_IDLE;
		end else if (CE) begin
			state_q <= state_d;
		end
	end

	// ************************************************************
	// Operand capture
	// ************************************************************
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			FILE_ADDR <= `BTS_ADDR_RST;
			bit_q <= `BTS_BIT_RST;
			kind_q <= bts_pkg::BTS_KIND_CLEAR;
			FILE_RD <= 1'b0;
		end else if (CE) begin
			FILE_RD <= take;
			if (take) begin
				FILE_ADDR <= INSTR[`BTS_ADR_MSB:`BTS_ADR_LSB];
				bit_q <= INSTR[`BTS_BIT_MSB:`BTS_BIT_LSB];
				kind_q <= is_set ? bts_pkg::BTS_KIND_SET : bts_pkg::BTS_KIND_CLEAR;
			end
		end
	end

	// ************************************************************
	// Result and flush
	// ************************************************************
	// The flush goes out with the result so fetch drops its prefetch in the NOP cycle
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			DONE <= 1'b0;
			FLUSH <= 1'b0;
			NOP_ACTIVE <= 1'b0;
			SKIP_TAKEN <= 1'b0;
			EXEC_CYCLES <= `BTS_CYC_NONE;
		end else if (CE) begin
			DONE <= (state_q == bts_pkg::BTS_READ);
			FLUSH <= skip_now;
			NOP_ACTIVE <= skip_now;
			if (state_q == bts_pkg::BTS_READ) begin
				SKIP_TAKEN <= skip_now;
				EXEC_CYCLES <= skip_now ? `BTS_CYC_SKIP : `BTS_CYC_PLAIN;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			BUSY <= 1'b0;
		end else if (CE) begin
			BUSY <= (state_d != bts_pkg::BTS_IDLE);
		end
	end

	// No write path exists: these strobes stay low forever
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			FILE_WE <= 1'b0;
			W_WE <= 1'b0;
			STATUS_WE <= 1'b0;
		end else if (CE) begin
			FILE_WE <= 1'b0;
			W_WE <= 1'b0;
			STATUS_WE <= 1'b0;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	chk_skip_clear: assert property (
		CE && state_q == bts_pkg::BTS_READ && kind_q == bts_pkg::BTS_KIND_CLEAR
		&& !FILE_RDATA[bit_q] |=> SKIP_TAKEN && FLUSH)
		else $error("Clear test with bit 0 did not skip");

	chk_skip_set: assert property (
		CE && state_q == bts_pkg::BTS_READ && kind_q == bts_pkg::BTS_KIND_SET
		&& FILE_RDATA[bit_q] |=> SKIP_TAKEN && FLUSH)
		else $error("Set test with bit 1 did not skip");

	chk_no_skip: assert property (
		CE && state_q == bts_pkg::BTS_READ && (kind_q == bts_pkg::BTS_KIND_SET) != FILE_RDATA[bit_q]
		|=> DONE && !SKIP_TAKEN && !FLUSH && !NOP_ACTIVE && EXEC_CYCLES == `BTS_CYC_PLAIN)
		else $error("Failed test still skipped");

	// A low enable in the NOP cycle stretches it, so BUSY may hold one more cycle
	chk_clear_two_cycles: assert property (
		CE && take && is_clear ##1 CE && !FILE_RDATA[bit_q]
		|=> NOP_ACTIVE && EXEC_CYCLES == `BTS_CYC_SKIP ##1 (!BUSY || !$past(CE)))
		else $error("Clear skip not two cycles with NOP");

	chk_set_two_cycles: assert property (
		CE && take && is_set ##1 CE && FILE_RDATA[bit_q]
		|=> NOP_ACTIVE && FLUSH && EXEC_CYCLES == `BTS_CYC_SKIP ##1 (!BUSY || !$past(CE)))
		else $error("Set skip not two cycles with NOP");

	chk_operand_fields: assert property (
		CE && take |=> FILE_RD && FILE_ADDR == $past(INSTR[`BTS_ADR_MSB:`BTS_ADR_LSB])
		&& bit_q == $past(INSTR[`BTS_BIT_MSB:`BTS_BIT_LSB]))
		else $error("Operand fields captured wrong");

	chk_decode_clear: assert property (
		CE && INSTR_VALID && state_q == bts_pkg::BTS_IDLE
		&& INSTR[`BTS_OPC_MSB:`BTS_OPC_LSB] == `BTS_OPC_CLEAR
		|=> BUSY && kind_q == bts_pkg::BTS_KIND_CLEAR)
		else $error("Skip-if-clear not decoded");

	chk_decode_set: assert property (
		CE && INSTR_VALID && state_q == bts_pkg::BTS_IDLE
		&& INSTR[`BTS_OPC_MSB:`BTS_OPC_LSB] == `BTS_OPC_SET
		|=> BUSY && kind_q == bts_pkg::BTS_KIND_SET)
		else $error("Skip-if-set not decoded");

	chk_decode_other: assert property (
		CE && state_q == bts_pkg::BTS_IDLE && INSTR[`BTS_OPC_MSB:`BTS_OPC_LSB] != `BTS_OPC_CLEAR
		&& INSTR[`BTS_OPC_MSB:`BTS_OPC_LSB] != `BTS_OPC_SET |=> !FILE_RD && !BUSY)
		else $error("Foreign opcode accepted");

	chk_no_writes: assert property (!FILE_WE && !W_WE && !STATUS_WE)
		else $error("Write strobe raised");

	chk_flush_pair: assert property (FLUSH |-> NOP_ACTIVE && DONE && SKIP_TAKEN && BUSY)
		else $error("Flush without its NOP cycle");

	chk_done_pulse: assert property (CE && DONE |=> !DONE)
		else $error("Result pulse longer than one cycle");

	// BUSY mirrors a non-idle state, so no read can start under it
	chk_busy_refuse: assert property (CE && BUSY |=> !FILE_RD)
		else $error("Instruction taken while busy");

	// Reset outranks a low enable, so the freeze is only checked out of reset
	chk_ce_freeze: assert property (
		RESET_N && !CE |=> $stable(state_q) && $stable(FILE_RD) && $stable(DONE)
		&& $stable(FLUSH) && $stable(BUSY))
		else $error("State moved while enable low");

	cov_clear_skip: cover property (take && is_clear ##1 skip_now);
	cov_set_skip: cover property (take && is_set ##1 skip_now);
	cov_no_skip: cover property (take ##1 CE && !skip_now);
	cov_stall_mid: cover property (take ##1 !CE ##1 CE && skip_now);
	cov_nop_stall: cover property (NOP_ACTIVE && !CE);

endmodule

/* verilog/bts_defs.svh */
// Encoding fields, opcodes and cycle counts of the bit-test-skip unit
`ifndef BTS_DEFS_SVH
`define BTS_DEFS_SVH

// Instruction word field positions
`define BTS_OPC_MSB 13
`define BTS_OPC_LSB 10
`define BTS_BIT_MSB 9
`define BTS_BIT_LSB 7
`define BTS_ADR_MSB 6
`define BTS_ADR_LSB 0

// Leading four opcode bits
`define BTS_OPC_CLEAR 4'h6
`define BTS_OPC_SET 4'h7

// Reset values
`define BTS_ADDR_RST 7'h00
`define BTS_BIT_RST 3'h0

// Execution length reported with the done pulse
`define BTS_CYC_NONE 2'h0
`define BTS_CYC_PLAIN 2'h1
`define BTS_CYC_SKIP 2'h2

`endif

/* verilog/bts_pkg.sv */
// Types shared by the bit-test-skip unit
package bts_pkg;

	typedef enum logic [1:0] {
		BTS_IDLE = 2'b00,
		BTS_READ = 2'b01,
		BTS_NOP = 2'b10
	} bts_state_t;

	typedef enum logic {
		BTS_KIND_CLEAR = 1'b0,
		BTS_KIND_SET = 1'b1
	} bts_kind_t;

endpackage

/* tb/bts_file_model.sv */
// File register array model answering the unit's reads
`timescale 1ns/1ps
module bts_file_model (
	// Read port from the unit
	input wire logic CLK,
	input wire logic FILE_RD,
	input wire logic [6:0] FILE_ADDR,
	output logic [7:0] FILE_RDATA
);
	logic [7:0] last_q = 8'h00;
	always_ff @(posedge CLK) begin
		last_q <= FILE_RDATA;
	end
	// Idle bus toggles so stale data never passes for an answer
	assign FILE_RDATA = FILE_RD ? ({1'b0, FILE_ADDR} ^ 8'h5A) : ~last_q;
endmodule

/* tb/bts_unit_tb_top.sv */
// Self-checking bench for the bit-test-skip unit
`timescale 1ns/1ps
module bts_unit_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic valid = 1'b0;
	logic [13:0] instr = 14'h0000;
	logic [7:0] rdata;
	logic rd, we, wwe, swe, busy, flush, nop, done, skip;
	logic [6:0] addr;
	logic [1:0] cyc;
	int bad_count = 0;
	int checked = 0;
	int ticks = 0;
	initial begin
		forever #5 clk = ~clk;
	end
	bts_unit dut (.CLK(clk), .RESET_N(rst_n), .CE(ce), .INSTR_VALID(valid),
		.INSTR(instr), .FILE_RDATA(rdata), .FILE_RD(rd), .FILE_ADDR(addr),
		.FILE_WE(we), .W_WE(wwe), .STATUS_WE(swe), .BUSY(busy), .FLUSH(flush),
		.NOP_ACTIVE(nop), .DONE(done), .SKIP_TAKEN(skip), .EXEC_CYCLES(cyc));
	bts_file_model mem (.CLK(clk), .FILE_RD(rd), .FILE_ADDR(addr), .FILE_RDATA(rdata));
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("bad %0d checked %0d", bad_count, checked);
		if (bad_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic exec(input logic [3:0] op, input logic [6:0] a, input logic [2:0] b);
		logic [7:0] d;
		logic s;
		d = {1'b0, a} ^ 8'h5A;
		s = op[0] ? d[b] : ~d[b];
		@(posedge clk);
		valid <= 1'b1;
		instr <= {op, b, a};
		@(posedge clk);
		valid <= 1'b0;
		#1;
		cmp({rd, addr}, {1'b1, a});
		@(posedge clk);
		#1;
		cmp({4'h0, done, skip, flush, nop}, {4'h1, s, s, s});
		cmp({5'h00, busy, cyc}, {5'h00, s, s ? 2'h2 : 2'h1});
		cmp({5'h00, we, wwe, swe}, 8'h00);
		if (s) begin
			@(posedge clk);
			#1;
			cmp({4'h0, busy, flush, nop, done}, 8'h00);
		end
	endtask
	task automatic t_clear;
		for (int b = 0; b < 8; b++) begin
			exec(4'h6, 7'h00, 3'(b));
			exec(4'h6, 7'h7F, 3'(b));
		end
	endtask
	task automatic t_set;
		for (int b = 0; b < 8; b++) begin
			exec(4'h7, 7'h00, 3'(b));
			exec(4'h7, 7'h7F, 3'(b));
		end
	endtask
	task automatic t_refuse;
		logic [3:0] ops [4] = '{4'h4, 4'h5, 4'hE, 4'h2};
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			valid <= 1'b1;
			instr <= {ops[k], 10'h085};
			@(posedge clk);
			valid <= 1'b0;
			#1;
			cmp({6'h00, rd, busy}, 8'h00);
		end
	endtask
	// Enable dropped in the read cycle and again in the result cycle
	task automatic exec_stall(input logic [3:0] op, input logic [6:0] a, input logic [2:0] b);
		logic [7:0] d;
		logic s;
		d = {1'b0, a} ^ 8'h5A;
		s = op[0] ? d[b] : ~d[b];
		@(posedge clk);
		valid <= 1'b1;
		instr <= {op, b, a};
		@(posedge clk);
		valid <= 1'b0;
		ce <= 1'b0;
		@(posedge clk);
		ce <= 1'b1;
		#1;
		cmp({rd, addr}, {1'b1, a});
		cmp({5'h00, busy, done, flush}, 8'h04);
		@(posedge clk);
		ce <= 1'b0;
		#1;
		cmp({4'h0, done, skip, flush, nop}, {4'h1, s, s, s});
		@(posedge clk);
		ce <= 1'b1;
		#1;
		cmp({4'h0, done, skip, flush, nop}, {4'h1, s, s, s});
		cmp({5'h00, busy, cyc}, {5'h00, s, s ? 2'h2 : 2'h1});
		@(posedge clk);
		#1;
		cmp({4'h0, busy, flush, nop, done}, 8'h00);
	endtask
	task automatic t_stall;
		exec_stall(4'h6, 7'h00, 3'h0);
		exec_stall(4'h7, 7'h00, 3'h0);
	endtask
	// Reset lands on a read in flight; held two edges so checks see a clean start
	task automatic t_reset;
		@(posedge clk);
		valid <= 1'b1;
		instr <= {4'h6, 3'h1, 7'h7F};
		@(posedge clk);
		valid <= 1'b0;
		rst_n <= 1'b0;
		@(posedge clk);
		#1;
		cmp({rd, busy, done, flush, nop, skip, cyc}, 8'h00);
		cmp({1'b0, addr}, 8'h00);
		@(posedge clk);
		rst_n <= 1'b1;
		#1;
		cmp({rd, busy, done, flush, nop, skip, cyc}, 8'h00);
		exec(4'h6, 7'h7F, 3'h1);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_clear();
		t_set();
		t_refuse();
		t_stall();
		t_reset();
		final_report();
	end
	always @(posedge clk) begin
		ticks++;
		if (ticks == 1000) begin
			bad_count++;
			final_report();
		end
	end
endmodule
